// ---- hdl/wda_pkg.sv ----
// Purpose: Shared constants and carrier types for the watchdog and auxiliary control block
// Assumes: Byte addresses on the register bus are four times the register index
// Notes: Registers are at most eight bits wide (status and mask three), in the low byte of a 32-bit bus word
package wda_pkg;
   // ==========================================================
   // Register indices (byte address = index * 4)
   localparam int ADR_W = 12;
   localparam logic [9:0] AUX_IDX = 10'h0A2;
   localparam logic [9:0] WDC_IDX = 10'h0A7;
   localparam logic [9:0] FEED_IDX = 10'h0A8;
   localparam logic [9:0] STAT_IDX = 10'h0A9;
   localparam logic [9:0] MASK_IDX = 10'h0AA;
   localparam logic [9:0] PTRL_IDX = 10'h0AB;
   localparam logic [9:0] PTRH_IDX = 10'h0AC;
   // ==========================================================
   // Field positions
   localparam int WDC_OVF_BIT = 5;
   localparam int WDC_RUN_BIT = 4;
   localparam int WDC_CLK_BIT = 3;
   localparam int AUX_KBF_BIT = 7;
   localparam int AUX_BOD_BIT = 6;
   localparam int AUX_BOI_BIT = 5;
   localparam int AUX_LOW_POWER_PROGRAM_MEMORY_BIT = 4;
   localparam int AUX_SOFTWARE_RESET_BIT_BIT = 3;
   localparam int AUX_ZERO_BIT = 2;
   localparam int AUX_DPS_BIT = 0;
   localparam int IRQ_WDT_BIT = 0;
   localparam int IRQ_KEY_BIT = 1;
   localparam int IRQ_BRN_BIT = 2;
   localparam int IRQ_W = 3;
   // ==========================================================
   // Reset values, write masks, feed codes and timing
   localparam logic [7:0] WDC_RST_WDT = 8'h30;
   localparam logic [7:0] WDC_RST_ON = 8'h10;
   localparam logic [7:0] WDC_RST_OFF = 8'h00;
   localparam logic [7:0] AUX_RST = 8'h00;
   localparam logic [7:0] WDC_WMASK = 8'h1F;
   localparam logic [7:0] AUX_WMASK = 8'hE1;
   localparam logic [7:0] FEED_FIRST = 8'h1E;
   localparam logic [7:0] FEED_SECOND = 8'hE1;
   localparam logic [2:0] CPU_DIV_LAST = 3'h5;
   localparam int TIMEOUT_BASE_DEF = 8192;
   localparam int CNT_W = 21;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wda_wb_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wda_wb_rsp_t;
   typedef struct packed {
      logic inc;
      logic load;
      logic [15:0] data;
   } wda_ptr_cmd_t;
endpackage

// ---- hdl/wda_top.sv ----
// Purpose: Watchdog control, feed logic, auxiliary control and dual data pointers
// Assumes: Wishbone classic slave, one clock; oscillator tick and pins synchronous to ref_clk_i
// Notes: chip_reset_o asks the system for a full chip reset; this block re-initialises itself
//
// Operation
// R1 - Watchdog control resets to 30H on watchdog reset, else 10H or 00H by fuse.
// R2 - Overflow flag sets on watchdog reset or overflow, clears on a completed feed.
// R3 - Run control starts or stops the counter; fuse forces it to one.
// R4 - Clock select picks CPU clock divided by 6 or the RC oscillator; fuse forces RC.
// R5 - Timeout select gives 8,192 clocks doubled per code up to 1,048,576.
// R6 - Software never writes ones to reserved watchdog bits 7, 6 or auxiliary bit 1.
// R7 - Keypad flag sets on enabled port 0 pin going low; only software clears it.
// R8 - Brownout-off control switches brownout detection off.
// R9 - Brownout-as-interrupt control turns brownout into an interrupt instead of a reset.
// R10 - Low-power memory bit is set-only; cleared by power-on or brownout reset only.
// R11 - Writing one to auxiliary bit 3 fully resets the chip.
// R12 - Auxiliary bit 2 always reads zero and ignores writes.
// R13 - Pointer select chooses one of two data pointers; the other stays hidden.
// R14 - Pointer operations and byte register accesses use the selected pointer.
// R15 - Auxiliary control resets to 00H and takes only whole-byte accesses.
// R16 - Feed is 1EH then E1H to the feed register; wrong sequences change nothing.
// R17 - With fuse off, the timer raises an interrupt instead of a reset.
// R18 - With fuse on, watchdog control takes only one write after reset.
// R19 - At the selected count: reset if fuse on, else interrupt; overflow flag set.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module wda_top #(
   parameter int TIMEOUT_BASE = wda_pkg::TIMEOUT_BASE_DEF
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire wda_pkg::wda_wb_req_t wb_req_i,
   output wda_pkg::wda_wb_rsp_t wb_rsp_o,
   input wire logic watchdog_enable_fuse_i,
   input wire logic wdt_osc_tick_i,
   input wire logic [7:0] keypad_pins_i,
   input wire logic [7:0] keypad_enable_i,
   input wire logic brownout_i,
   input wire wda_pkg::wda_ptr_cmd_t ptr_cmd_i,
   output logic [15:0] data_pointer_o,
   output logic brownout_detect_en_o,
   output logic low_power_program_memory_o,
   output logic chip_reset_o,
   output logic irq_o
);
   import wda_pkg::*;

   // ==========================================================
   // State
   logic [7:0] wdc_ff, nxt_wdc;
   logic [7:0] aux_ff, nxt_aux;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [2:0] pre_ff, nxt_pre;
   logic armed_ff, nxt_armed;
   logic wdc_done_ff, nxt_wdc_done;
   logic init_ff, nxt_init;
   logic [IRQ_W-1:0] stat_ff, nxt_stat;
   logic [IRQ_W-1:0] mask_ff, nxt_mask;
   logic [15:0] ptr0_ff, nxt_ptr0;
   logic [15:0] ptr1_ff, nxt_ptr1;
   logic [7:0] keys_ff, nxt_keys;
   logic brn_ff, nxt_brn;
   logic rst_ff, nxt_rst;
   logic ack_ff, nxt_ack;
   logic [31:0] rdat_ff, nxt_rdat;

   // ==========================================================
   // Bus decode
   logic req;
   logic wr;
   logic [9:0] idx;
   logic [7:0] wbyte;
   logic wr_aux, wr_wdc, wr_feed, wr_stat, wr_mask, wr_ptrl, wr_ptrh;

   // Write takes effect at the edge where ack is high, matching the master's sampling
   assign req = wb_req_i.cyc && wb_req_i.stb;
   assign wr = req && wb_req_i.we && ack_ff && wb_req_i.sel[0]; // R15
   assign idx = wb_req_i.adr[ADR_W-1:2];
   assign wbyte = wb_req_i.dat[7:0];
   assign wr_aux = wr && (idx == AUX_IDX);
   assign wr_wdc = wr && (idx == WDC_IDX);
   assign wr_feed = wr && (idx == FEED_IDX);
   assign wr_stat = wr && (idx == STAT_IDX);
   assign wr_mask = wr && (idx == MASK_IDX);
   assign wr_ptrl = wr && (idx == PTRL_IDX);
   assign wr_ptrh = wr && (idx == PTRH_IDX);

   // ==========================================================
   // Events
   logic fuse;
   logic tick;
   logic [CNT_W-1:0] limit;
   logic ovf_evt;
   logic feed_ok;
   logic [7:0] key_fall;
   logic brn_rise;
   logic brn_rst_evt, brn_irq_evt;
   logic wdt_rst_evt, sw_rst_evt, any_rst;
   logic [15:0] ptr_sel;

   assign fuse = watchdog_enable_fuse_i;
   assign tick = wdc_ff[WDC_CLK_BIT] ? (pre_ff == CPU_DIV_LAST) : wdt_osc_tick_i; // R4
   // Limit is one below the count: overflow lands on the tick that completes it
   assign limit = (CNT_W'(TIMEOUT_BASE) << wdc_ff[2:0]) - CNT_W'(1); // R5
   assign ovf_evt = wdc_ff[WDC_RUN_BIT] && tick && (cnt_ff == limit) && !init_ff; // R19
   assign feed_ok = wr_feed && armed_ff && (wbyte == FEED_SECOND); // R16
   // Detector resets high, the idle pin level, so reset never fakes a key press
   assign key_fall = keys_ff & ~keypad_pins_i & keypad_enable_i; // R7
   // Detection is gated off entirely while the brownout-off control is set
   assign brn_rise = brownout_i && !brn_ff && !aux_ff[AUX_BOD_BIT]; // R8
   assign brn_irq_evt = brn_rise && aux_ff[AUX_BOI_BIT]; // R9
   assign brn_rst_evt = brn_rise && !aux_ff[AUX_BOI_BIT]; // R9
   assign wdt_rst_evt = ovf_evt && fuse; // R19
   assign sw_rst_evt = wr_aux && wbyte[AUX_SOFTWARE_RESET_BIT_BIT]; // R11
   assign any_rst = wdt_rst_evt || sw_rst_evt || brn_rst_evt;
   // Only the selected pointer is ever visible outside the block
   assign ptr_sel = aux_ff[AUX_DPS_BIT] ? ptr1_ff : ptr0_ff; // R13

   // ==========================================================
   // Watchdog control and counter
   always_comb begin
      nxt_wdc = wdc_ff;
      nxt_cnt = cnt_ff;
      // Prescaler runs freely; switching to the CPU clock may shorten the first tick
      nxt_pre = (pre_ff == CPU_DIV_LAST) ? 3'h0 : pre_ff + 3'h1;
      nxt_armed = armed_ff;
      nxt_wdc_done = wdc_done_ff;
      nxt_init = 1'b0;
      if (init_ff || sw_rst_evt || brn_rst_evt) begin
         // Fuse is sampled after reset release, never under the asynchronous reset
         nxt_wdc = fuse ? WDC_RST_ON : WDC_RST_OFF; // R1
         // An overflow in the same cycle as another reset still leaves its flag
         nxt_wdc[WDC_OVF_BIT] = ovf_evt; // R2
         nxt_cnt = '0;
         nxt_armed = 1'b0;
         nxt_wdc_done = 1'b0;
      end else if (wdt_rst_evt) begin
         nxt_wdc = WDC_RST_WDT; // R1
         nxt_cnt = '0;
         nxt_armed = 1'b0;
         nxt_wdc_done = 1'b0;
      end else begin
         if (wr_wdc && !(fuse && wdc_done_ff)) begin // R18
            nxt_wdc = (wdc_ff & ~WDC_WMASK) | (wbyte & WDC_WMASK);
            nxt_wdc_done = 1'b1;
         end
         if (wr_feed) begin
            nxt_armed = (wbyte == FEED_FIRST); // R16
         end
         if (feed_ok) begin
            nxt_cnt = '0; // R16
            nxt_wdc[WDC_OVF_BIT] = 1'b0; // R2
         end else if (wdc_ff[WDC_RUN_BIT] && tick) begin // R3
            nxt_cnt = (cnt_ff == limit) ? '0 : cnt_ff + CNT_W'(1); // R5
         end
         // Overflow wins over a feed landing in the same cycle
         if (ovf_evt) begin
            nxt_wdc[WDC_OVF_BIT] = 1'b1; // R2
         end
      end
      if (fuse) begin
         nxt_wdc[WDC_RUN_BIT] = 1'b1; // R3
         nxt_wdc[WDC_CLK_BIT] = 1'b0; // R4
      end
      // Reserved bits read zero whatever software writes
      nxt_wdc[7:6] = 2'b00;
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wdc_ff <= WDC_RST_OFF;
         cnt_ff <= '0;
         pre_ff <= 3'h0;
         armed_ff <= 1'b0;
         wdc_done_ff <= 1'b0;
         init_ff <= 1'b1;
      end else begin
         wdc_ff <= nxt_wdc;
         cnt_ff <= nxt_cnt;
         pre_ff <= nxt_pre;
         armed_ff <= nxt_armed;
         wdc_done_ff <= nxt_wdc_done;
         init_ff <= nxt_init;
      end
   end

   // ==========================================================
   // Auxiliary control, data pointers, interrupts
   always_comb begin
      nxt_aux = aux_ff;
      nxt_ptr0 = ptr0_ff;
      nxt_ptr1 = ptr1_ff;
      nxt_stat = stat_ff;
      nxt_mask = mask_ff;
      nxt_keys = keypad_pins_i;
      nxt_brn = brownout_i;
      nxt_rst = any_rst;
      if (any_rst) begin
         // Low-power bit survives software and watchdog resets
         nxt_aux = AUX_RST; // R15
         nxt_aux[AUX_LOW_POWER_PROGRAM_MEMORY_BIT] = aux_ff[AUX_LOW_POWER_PROGRAM_MEMORY_BIT] && !brn_rst_evt; // R10
         nxt_ptr0 = 16'h0000;
         nxt_ptr1 = 16'h0000;
         nxt_stat = '0;
         nxt_mask = '0;
      end else begin
         if (wr_aux) begin
            nxt_aux = (aux_ff & ~AUX_WMASK) | (wbyte & AUX_WMASK); // R12
            nxt_aux[AUX_LOW_POWER_PROGRAM_MEMORY_BIT] = aux_ff[AUX_LOW_POWER_PROGRAM_MEMORY_BIT] | wbyte[AUX_LOW_POWER_PROGRAM_MEMORY_BIT]; // R10
         end
         if (|key_fall) begin
            nxt_aux[AUX_KBF_BIT] = 1'b1; // R7
         end
         if (wr_stat) begin
            nxt_stat = stat_ff & ~wbyte[IRQ_W-1:0];
         end
         if (wr_mask) begin
            nxt_mask = wbyte[IRQ_W-1:0];
         end
         // Set wins over a write-one clear in the same cycle
         if (ovf_evt) begin
            nxt_stat[IRQ_WDT_BIT] = 1'b1; // R17
         end
         if (|key_fall) begin
            nxt_stat[IRQ_KEY_BIT] = 1'b1;
         end
         if (brn_irq_evt) begin
            nxt_stat[IRQ_BRN_BIT] = 1'b1; // R9
         end
         if (aux_ff[AUX_DPS_BIT]) begin // R14
            if (ptr_cmd_i.load) begin
               nxt_ptr1 = ptr_cmd_i.data;
            end else if (ptr_cmd_i.inc) begin
               nxt_ptr1 = ptr1_ff + 16'h0001;
            end
            if (wr_ptrl) begin
               nxt_ptr1[7:0] = wbyte;
            end
            if (wr_ptrh) begin
               nxt_ptr1[15:8] = wbyte;
            end
         end else begin
            if (ptr_cmd_i.load) begin
               nxt_ptr0 = ptr_cmd_i.data;
            end else if (ptr_cmd_i.inc) begin
               nxt_ptr0 = ptr0_ff + 16'h0001;
            end
            if (wr_ptrl) begin
               nxt_ptr0[7:0] = wbyte;
            end
            if (wr_ptrh) begin
               nxt_ptr0[15:8] = wbyte;
            end
         end
      end
      // Hard-wired zero, self-clearing reset strobe and reserved bit
      nxt_aux[AUX_ZERO_BIT] = 1'b0; // R12
      nxt_aux[AUX_SOFTWARE_RESET_BIT_BIT] = 1'b0;
      nxt_aux[1] = 1'b0;
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aux_ff <= AUX_RST;
         ptr0_ff <= 16'h0000;
         ptr1_ff <= 16'h0000;
         stat_ff <= '0;
         mask_ff <= '0;
         keys_ff <= 8'hFF;
         brn_ff <= 1'b0;
         rst_ff <= 1'b0;
      end else begin
         aux_ff <= nxt_aux;
         ptr0_ff <= nxt_ptr0;
         ptr1_ff <= nxt_ptr1;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         keys_ff <= nxt_keys;
         brn_ff <= nxt_brn;
         rst_ff <= nxt_rst;
      end
   end

   // ==========================================================
   // Bus answer: ack one cycle after the request, unmapped reads return zero
   always_comb begin
      // One request outstanding; ack drops in the cycle after it was given
      nxt_ack = req && !ack_ff;
      nxt_rdat = 32'h0000_0000;
      unique case (idx)
         AUX_IDX: nxt_rdat[7:0] = aux_ff;
         WDC_IDX: nxt_rdat[7:0] = wdc_ff;
         STAT_IDX: nxt_rdat[IRQ_W-1:0] = stat_ff;
         MASK_IDX: nxt_rdat[IRQ_W-1:0] = mask_ff;
         PTRL_IDX: nxt_rdat[7:0] = ptr_sel[7:0]; // R14
         PTRH_IDX: nxt_rdat[7:0] = ptr_sel[15:8]; // R14
         default: nxt_rdat = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
      end
   end

   assign wb_rsp_o.ack = ack_ff;
   assign wb_rsp_o.dat = rdat_ff;
   assign data_pointer_o = ptr_sel;
   assign brownout_detect_en_o = !aux_ff[AUX_BOD_BIT]; // R8
   assign low_power_program_memory_o = aux_ff[AUX_LOW_POWER_PROGRAM_MEMORY_BIT];
   assign chip_reset_o = rst_ff; // R11
   // Level interrupt: stays high until software clears the status bit
   assign irq_o = |(stat_ff & mask_ff);

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   // Internal resets are excluded where they rightly win over the guarded event
   a_fuse_forces_run: assert property (fuse && !init_ff && $past(fuse) // R3
      |-> wdc_ff[WDC_RUN_BIT] && !wdc_ff[WDC_CLK_BIT]) else $error("fuse did not force run");
   a_count_in_range: assert property (!init_ff |-> cnt_ff <= limit) // R5
      else $error("counter beyond timeout");
   a_ovf_sets_flag: assert property (ovf_evt |=> wdc_ff[WDC_OVF_BIT]) // R2
      else $error("overflow flag not set");
   a_ovf_resets_chip: assert property (ovf_evt && fuse |=> chip_reset_o && wdc_ff == WDC_RST_WDT) // R1
      else $error("watchdog reset missing");
   a_ovf_interval_irq: assert property (ovf_evt && !fuse && !sw_rst_evt && !brn_rst_evt // R17
      |=> stat_ff[IRQ_WDT_BIT] && !chip_reset_o) else $error("interval interrupt missing");
   a_feed_clears: assert property (feed_ok && !any_rst && !ovf_evt && !init_ff // R16
      |=> cnt_ff == '0 && !wdc_ff[WDC_OVF_BIT]) else $error("feed did not restart");
   a_bad_feed_keeps: assert property (wr_feed && !feed_ok && !ovf_evt && !any_rst && !init_ff // R16
      |=> wdc_ff[WDC_OVF_BIT] == $past(wdc_ff[WDC_OVF_BIT])) else $error("bad feed changed state");
   a_write_once: assert property (fuse && wdc_done_ff && wr_wdc && !ovf_evt && !any_rst && !init_ff // R18
      |=> wdc_ff[2:0] == $past(wdc_ff[2:0])) else $error("second write accepted");
   a_soft_reset: assert property (sw_rst_evt |=> chip_reset_o ##0 aux_ff[7:5] == 3'b000) // R11
      else $error("software reset missing");
   a_low_power_program_memory_sticky: assert property (aux_ff[AUX_LOW_POWER_PROGRAM_MEMORY_BIT] && !brn_rst_evt |=> aux_ff[AUX_LOW_POWER_PROGRAM_MEMORY_BIT]) // R10
      else $error("low power bit cleared");
   a_kbf_sw_clear: assert property ($fell(aux_ff[AUX_KBF_BIT]) |-> $past(wr_aux || any_rst)) // R7
      else $error("keypad flag cleared by hardware");
   a_bit2_zero: assert property (!aux_ff[AUX_ZERO_BIT]) else $error("bit 2 not zero"); // R12
   a_ptr_inc: assert property (ptr_cmd_i.inc && !ptr_cmd_i.load && !wr_ptrl && !wr_ptrh // R14
      && !wr_aux && !any_rst |=> data_pointer_o == $past(data_pointer_o) + 16'h0001)
      else $error("selected pointer not incremented");
   a_brown_no_reset: assert property (brn_irq_evt && !sw_rst_evt && !wdt_rst_evt // R9
      |=> !chip_reset_o && stat_ff[IRQ_BRN_BIT]) else $error("brownout reset despite interrupt mode");
   a_init_value: assert property (init_ff |=> wdc_ff == ($past(fuse) ? WDC_RST_ON : WDC_RST_OFF)) // R1
      else $error("watchdog control reset value wrong");
   a_ack_pulse: assert property (ack_ff |=> !ack_ff)
      else $error("ack held longer than one cycle");
   a_brown_clears_low_power_program_memory: assert property (brn_rst_evt |=> chip_reset_o && !low_power_program_memory_o) // R10
      else $error("brownout reset kept low power bit");
   a_unsel_hidden: assert property (!aux_ff[AUX_DPS_BIT] && !any_rst |=> ptr1_ff == $past(ptr1_ff)) // R13
      else $error("hidden pointer changed");
   a_ptr_load: assert property (ptr_cmd_i.load && !wr_ptrl && !wr_ptrh && !wr_aux && !any_rst // R14
      |=> data_pointer_o == $past(ptr_cmd_i.data)) else $error("selected pointer not loaded");
   a_keypad_sets: assert property (|key_fall && !any_rst |=> aux_ff[AUX_KBF_BIT] && stat_ff[IRQ_KEY_BIT]) // R7
      else $error("keypad event lost");
   a_stopped_holds: assert property (!wdc_ff[WDC_RUN_BIT] && !feed_ok && !any_rst && !init_ff // R3
      |=> cnt_ff == $past(cnt_ff)) else $error("stopped counter moved");

   // Main scenarios
   c_watchdog_reset: cover property (wdt_rst_evt);
   c_feed_done: cover property (feed_ok);
   c_keypad: cover property (|key_fall);
   c_irq: cover property (irq_o);
   c_soft_reset: cover property (sw_rst_evt);
endmodule
`default_nettype wire

// ---- bench/wda_tb.sv ----
// Purpose: Self-checking bench for the watchdog and auxiliary control block
// Assumes: TIMEOUT_BASE of 8 so every timeout fits in a short run
// Notes: Oscillator ticks are issued by hand so the moment of overflow is exact
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wda_pkg::*;
   localparam int BASE = 8;
   logic clk, rstn, fuse, tick, brown, bod_en, low_power_program_memory, crst, irq;
   logic [7:0] pins, kena;
   logic [15:0] data_pointer;
   wda_wb_req_t req;
   wda_wb_rsp_t rsp;
   wda_ptr_cmd_t pcmd;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n_rst = 0;
   int n0;

   wda_top #(.TIMEOUT_BASE(BASE)) i_wda_top (.ref_clk_i(clk), .rstn_i(rstn), .wb_req_i(req), .wb_rsp_o(rsp),
      .watchdog_enable_fuse_i(fuse), .wdt_osc_tick_i(tick), .keypad_pins_i(pins), .keypad_enable_i(kena),
      .brownout_i(brown), .ptr_cmd_i(pcmd), .data_pointer_o(data_pointer), .brownout_detect_en_o(bod_en),
      .low_power_program_memory_o(low_power_program_memory), .chip_reset_o(crst), .irq_o(irq));

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // Internal reset requests are counted so scenarios compare counts
   always @(posedge clk) begin
      if (crst === 1'h1) n_rst <= n_rst + 1;
   end

   // ==========================================================
   // Shared tasks
   task automatic stop_test();
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits for ack without a limit of its own; the watchdog process ends a hang
   task automatic wb(input logic we, input logic [9:0] idx, input logic [7:0] d, output logic [7:0] q);
      if (we && ((idx == WDC_IDX && d[7:6] != 2'h0) || (idx == AUX_IDX && d[1]))) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: write sets a reserved bit", $time);
      end
      @(posedge clk);
      req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: {idx, 2'h0}, sel: 4'hF, dat: {24'h0, d}};
      do begin
         @(posedge clk);
      end while (rsp.ack !== 1'h1);
      q = rsp.dat[7:0];
      req <= '0;
   endtask

   // Ends at a falling edge so port checks see the committed write
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'h1, idx, d, q);
      @(negedge clk);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'h0, idx, 8'h00, q);
      chk({8'h00, q}, {8'h00, exp});
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk) tick <= 1'h1;
         @(posedge clk) tick <= 1'h0;
      end
   endtask

   task automatic feed();
      wr(FEED_IDX, 8'h1E);
      wr(FEED_IDX, 8'hE1);
   endtask

   task automatic do_reset(input logic f);
      @(posedge clk);
      rstn <= 1'h0;
      fuse <= f;
      repeat (12) @(posedge clk);
      rstn <= 1'h1;
      @(posedge clk);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_aux();
      rd(WDC_IDX, 8'h00);
      rd(AUX_IDX, 8'h00);
      rd(10'h0B0, 8'h00);
      wr(AUX_IDX, 8'h75);
      rd(AUX_IDX, 8'h71);
      chk(bod_en, 16'h0);
      chk(low_power_program_memory, 16'h1);
      wr(AUX_IDX, 8'h00);
      rd(AUX_IDX, 8'h10);
      chk(bod_en, 16'h1);
   endtask

   task automatic t_ptr();
      wr(PTRL_IDX, 8'h34);
      wr(PTRH_IDX, 8'h12);
      chk(data_pointer, 16'h1234);
      wr(AUX_IDX, 8'h11);
      chk(data_pointer, 16'h0000);
      @(posedge clk) pcmd <= '{inc: 1'h0, load: 1'h1, data: 16'hABCD};
      @(posedge clk) pcmd <= '{inc: 1'h1, load: 1'h0, data: 16'h0000};
      @(posedge clk) pcmd <= '0;
      @(negedge clk);
      chk(data_pointer, 16'hABCE);
      rd(PTRH_IDX, 8'hAB);
      wr(AUX_IDX, 8'h10);
      chk(data_pointer, 16'h1234);
      n0 = n_rst;
      wr(AUX_IDX, 8'h18);
      repeat (3) @(posedge clk);
      chk(16'(n_rst - n0), 16'h1);
      chk(data_pointer, 16'h0000);
      rd(AUX_IDX, 8'h10);
   endtask

   task automatic t_key();
      @(posedge clk) pins <= 8'hFE;
      repeat (4) @(posedge clk);
      rd(AUX_IDX, 8'h90);
      rd(STAT_IDX, 8'h02);
      wr(MASK_IDX, 8'h02);
      chk(irq, 16'h1);
      @(posedge clk) pins <= 8'hFF;
      wr(STAT_IDX, 8'h02);
      chk(irq, 16'h0);
      rd(AUX_IDX, 8'h90);
      wr(AUX_IDX, 8'h10);
      rd(AUX_IDX, 8'h10);
   endtask

   task automatic t_interval();
      n0 = n_rst;
      wr(MASK_IDX, 8'h01);
      for (int c = 0; c < 3; c++) begin
         wr(WDC_IDX, 8'h10 | 8'(c));
         feed();
         wr(STAT_IDX, 8'h01);
         ticks((BASE << c) - 1);
         rd(STAT_IDX, 8'h00);
         ticks(1);
         rd(STAT_IDX, 8'h01);
      end
      chk(irq, 16'h1);
      chk(16'(n_rst - n0), 16'h0);
      rd(WDC_IDX, 8'h32);
      wr(FEED_IDX, 8'h1E);
      wr(FEED_IDX, 8'h55);
      wr(FEED_IDX, 8'hE1);
      rd(WDC_IDX, 8'h32);
      feed();
      rd(WDC_IDX, 8'h12);
      wr(WDC_IDX, 8'h00);
      wr(STAT_IDX, 8'h01);
      ticks(40);
      rd(STAT_IDX, 8'h00);
      wr(WDC_IDX, 8'h18);
      feed();
      repeat (30) @(posedge clk);
      rd(STAT_IDX, 8'h00);
      repeat (30) @(posedge clk);
      rd(STAT_IDX, 8'h01);
      wr(WDC_IDX, 8'h00);
      wr(STAT_IDX, 8'h01);
   endtask

   task automatic t_brown();
      n0 = n_rst;
      wr(AUX_IDX, 8'h30);
      @(posedge clk) brown <= 1'h1;
      repeat (3) @(posedge clk);
      rd(STAT_IDX, 8'h04);
      chk(16'(n_rst - n0), 16'h0);
      @(posedge clk) brown <= 1'h0;
      wr(STAT_IDX, 8'h04);
      wr(AUX_IDX, 8'h70);
      @(posedge clk) brown <= 1'h1;
      repeat (3) @(posedge clk);
      rd(STAT_IDX, 8'h00);
      @(posedge clk) brown <= 1'h0;
      wr(AUX_IDX, 8'h10);
      @(posedge clk) brown <= 1'h1;
      repeat (3) @(posedge clk);
      chk(16'(n_rst - n0), 16'h1);
      chk(low_power_program_memory, 16'h0);
      @(posedge clk) brown <= 1'h0;
   endtask

   task automatic t_wdt();
      do_reset(1'h1);
      rd(WDC_IDX, 8'h10);
      wr(WDC_IDX, 8'h08);
      rd(WDC_IDX, 8'h10);
      wr(WDC_IDX, 8'h03);
      rd(WDC_IDX, 8'h10);
      feed();
      n0 = n_rst;
      ticks(BASE - 1);
      chk(16'(n_rst - n0), 16'h0);
      ticks(1);
      repeat (3) @(posedge clk);
      chk(16'(n_rst - n0), 16'h1);
      rd(WDC_IDX, 8'h30);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      rstn = 1'h0;
      fuse = 1'h0;
      tick = 1'h0;
      brown = 1'h0;
      pins = 8'hFF;
      kena = 8'h01;
      req = '0;
      pcmd = '0;
      do_reset(1'h0);
      t_aux();
      t_ptr();
      t_key();
      t_interval();
      t_brown();
      t_wdt();
      stop_test();
   end

   // Whole run needs well under a thousand cycles; this bound is far above that
   initial begin
      #200us;
      n_mismatch++;
      stop_test();
   end
endmodule
`default_nettype wire
